// File: logic/position_result_and_nvm_access.sv
// Purpose: Result registers, NVM word/page programming and serial port
// Assumes: Serial clock is slow against mclk_in and sampled by it
// Notes: Command word bit 15 set reads, bits 9:0 carry the offset
`timescale 1ns/100ps
`default_nettype none

// How it works
// R1: Temperature register, value/200 plus 25 gives C
// R2: Four read-only pixel field registers, ~4mT LSB
// R3: Absolute mode magnitude from pixel 1 fields
// R4: Differential mode magnitude from pixel differences
// R5: Raw angle scaled by range extension setting
// R6: Linearized 16-bit position register, same scaling
// R7: 1kx8 NVM configured through serial port
// R8: NVM holds sequencer, PWM, magnet-lost words
// R9: 33 linearization entries mapped from NVM addresses
// R10: Address register then data register reads NVM
// R11: Single write: address, data, done flag set
// R12: Host waits for done, ~10 ms per word
// R13: Done flag low while programming, high after
// R14: Eight-word page written in one cycle
// R15: Host writes seven page words, eighth via data
// R16: Page words buffered, final write starts programming
// R17: Done flag set after page stored
// R18: Span widens from 180 to 288 degrees
// R19: Sequencer bit 11 enables range extension
// R20: Bit 10 with orientation negates position
// R21: Ready set on results, cleared by read
// R22: Output data driven only while selected
// R23: Select may stay low across commands
// R24: Clock pin monitors or accepts clock
// R25: Read-only checksum register
module position_result_and_nvm_access
   import pos_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = NVM_WRITE_CYC, // Programming time in cycles
   parameter int unsigned NVM_WORDS = 512 // 1kx8 as 16-bit words
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic sclk_in,
   input wire logic mosi_in,
   input wire logic cs_n_in,
   output logic miso_out,
   output logic miso_oe_out,
   output logic ready_out,
   input wire logic clk_pin_in,
   output logic clk_pin_out,
   output logic clk_pin_oe_out,
   input wire logic clk_ext_select_in,
   output logic ext_clk_tick_out,
   input wire logic meas_done_in,
   input wire logic [15:0] temperature_in,
   input wire logic [15:0] pixel1_z_field_in,
   input wire logic [15:0] pixel0_z_field_in,
   input wire logic [15:0] pixel1_x_field_in,
   input wire logic [15:0] pixel0_x_field_in,
   input wire logic [15:0] magnitude_in,
   input wire logic [15:0] raw_angle_in,
   input wire logic [15:0] linearized_position_in,
   input wire logic [15:0] checksum_in,
   input wire logic magnet_orientation_in,
   input wire logic signed [5:0] lin_index_in,
   output logic [15:0] lin_entry_out,
   output logic [15:0] cordic_z_out,
   output logic [15:0] cordic_x_out,
   output logic range_extension_enable_out,
   output logic differential_select_out
);
   localparam int CW = $clog2(WRITE_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [2:0] sclk_q; // Serial clock, bit 2 for edges
   logic [1:0] mosi_q; // Serial data in
   logic [1:0] csn_q; // Select, active low
   logic [2:0] cpin_q; // Clock pin, bit 2 for edges
   logic [1:0] extsel_q; // External clock strap

   // Two flops per pin before any logic
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sclk_q <= 3'h0;
         mosi_q <= 2'h0;
         csn_q <= 2'h3;
         cpin_q <= 3'h0;
         extsel_q <= 2'h0;
      end else if (ce_in) begin
         sclk_q <= {sclk_q[1:0], sclk_in};
         mosi_q <= {mosi_q[0], mosi_in};
         csn_q <= {csn_q[0], cs_n_in};
         cpin_q <= {cpin_q[1:0], clk_pin_in};
         extsel_q <= {extsel_q[0], clk_ext_select_in};
      end
   end

   wire sclk_rise = sclk_q[1] & ~sclk_q[2];
   wire sclk_fall = ~sclk_q[1] & sclk_q[2];
   wire cs_act = ~csn_q[1];

   ////////////////////////////////////////////////////////////////////////
   // Serial frame engine
   logic [4:0] cnt_q; // Bits taken in this frame
   logic [15:0] sh_q; // Receive shifter
   logic cmd_rd_q; // Current command is a read
   logic [9:0] cmd_adr_q; // Current command offset
   logic [15:0] tx_q; // Transmit shifter
   logic [15:0] rd_data; // Read mux

   wire [15:0] sh_nx = {sh_q[14:0], mosi_q[1]};
   wire cmd_end = cs_act & sclk_rise & (cnt_q == CMD_LAST);
   wire dat_end = cs_act & sclk_rise & (cnt_q == DAT_LAST);
   wire rd_stb = cmd_end & sh_nx[CMD_READ_BIT];
   wire [9:0] rd_adr = sh_nx[9:0];
   wire wr_stb = dat_end & ~cmd_rd_q;

   // Counter wraps after 32 bits so select may stay low
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         cnt_q <= 5'h00;
         sh_q <= 16'h0000;
         cmd_rd_q <= 1'b0;
         cmd_adr_q <= 10'h000;
         tx_q <= 16'h0000;
      end else if (ce_in) begin
         if (!cs_act) begin
            cnt_q <= 5'h00; // Deselect aborts the frame
            tx_q <= 16'h0000;
         end else begin
            if (sclk_rise) begin // see R23
               sh_q <= sh_nx;
               cnt_q <= 5'(cnt_q + 5'h01);
            end
            if (cmd_end) begin
               cmd_rd_q <= sh_nx[CMD_READ_BIT];
               cmd_adr_q <= sh_nx[9:0];
               tx_q <= sh_nx[CMD_READ_BIT] ? rd_data : 16'h0000;
            end else if (sclk_fall && cnt_q >= TX_SHIFT_FROM) begin
               tx_q <= {tx_q[14:0], 1'b0};
            end
         end
      end
   end

   // Output driven only while selected
   assign miso_out = tx_q[15];
   assign miso_oe_out = cs_act; // see R22

   ////////////////////////////////////////////////////////////////////////
   // Configuration and NVM programming
   logic [15:0] seq_q; // Sequencer control shadow
   logic [15:0] nadr_q; // NVM word address
   logic [15:0] padr_q; // Page write address
   logic [15:0] pbuf_q [8]; // Volatile page buffer
   logic [7:0] pval_q; // Page buffer slots filled
   logic [15:0] nvm_q [NVM_WORDS]; // Non-volatile array
   nvm_state_e st_q; // Programming engine state
   logic [CW-1:0] wcnt_q; // Programming time left
   logic done_q; // Write done flag
   logic cm_page_q; // Commit includes page buffer
   logic [8:0] cm_adr_q; // Final word address
   logic [15:0] cm_dat_q; // Final word data
   logic reload_q; // Refresh shadow after commit

   wire idle = (st_q == NVM_IDLE);
   wire prog_go = wr_stb & (cmd_adr_q == ADR_NVM_DAT) & idle;
   wire pg_wr = wr_stb & (cmd_adr_q == ADR_PG_DAT) & idle;
   wire commit = (st_q == NVM_BUSY) & (wcnt_q == '0);
   wire page_mode = |pval_q;
   wire [15:0] nvm_rd = nvm_q[nadr_q[8:0]];

   // Host writes, engine start and done flag
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         seq_q <= SEQ_RESET;
         nadr_q <= 16'h0000;
         padr_q <= 16'h0000;
         pval_q <= 8'h00;
         st_q <= NVM_IDLE;
         wcnt_q <= '0;
         done_q <= 1'b1;
         cm_page_q <= 1'b0;
         cm_adr_q <= 9'h000;
         cm_dat_q <= 16'h0000;
         reload_q <= 1'b0;
      end else if (ce_in) begin
         reload_q <= commit;
         if (reload_q) begin
            seq_q <= nvm_q[NVM_SEQ_WORD]; // see R8
         end else if (wr_stb && cmd_adr_q == ADR_SEQ) begin
            seq_q <= sh_nx;
         end
         if (wr_stb && cmd_adr_q == ADR_NVM_ADR) begin
            nadr_q <= sh_nx; // see R10
         end
         if (wr_stb && cmd_adr_q == ADR_PG_ADR) begin
            padr_q <= sh_nx;
         end
         if (pg_wr) begin
            pval_q[padr_q[2:0]] <= 1'b1; // see R16
         end
         unique case (st_q)
            NVM_IDLE: begin
               if (prog_go) begin // see R11
                  st_q <= NVM_BUSY;
                  done_q <= 1'b0; // see R13
                  wcnt_q <= CW'(WRITE_CYCLES - 1);
                  cm_page_q <= page_mode; // see R14
                  cm_adr_q <= page_mode ? padr_q[8:0] : nadr_q[8:0];
                  cm_dat_q <= sh_nx;
               end
            end
            NVM_BUSY: begin
               if (commit) begin
                  st_q <= NVM_IDLE;
                  done_q <= 1'b1; // see R17
                  pval_q <= 8'h00;
               end else begin
                  wcnt_q <= CW'(wcnt_q - 1'b1);
               end
            end
         endcase
      end
   end

   // Page buffer fill, no reset needed
   always_ff @(posedge mclk_in) begin
      if (ce_in && pg_wr) begin
         pbuf_q[padr_q[2:0]] <= sh_nx;
      end
   end

   // Array keeps contents across reset
   always_ff @(posedge mclk_in) begin
      if (ce_in && commit) begin
         for (int i = 0; i < 8; i++) begin
            if (cm_page_q && pval_q[i]) begin
               nvm_q[{cm_adr_q[8:3], 3'(i)}] <= pbuf_q[i]; // see R14
            end
         end
         nvm_q[cm_adr_q] <= cm_dat_q; // see R7
      end
   end

   // Sequencer control fields
   assign range_extension_enable_out = seq_q[BIT_RANGE_EXT]; // see R19
   assign differential_select_out = seq_q[BIT_DIFF];
   wire coord_sel = seq_q[BIT_COORD];

   ////////////////////////////////////////////////////////////////////////
   // Linearization table lookup
   function automatic logic [8:0] lin_addr(input logic signed [5:0] i);
      if (i >= 6'sd16) begin
         lin_addr = LIN_ENTRY16;
      end else if (i >= 6'sd0) begin
         lin_addr = LIN_POS_BASE + 9'(i[3:0]);
      end else if (i >= -6'sd16) begin
         lin_addr = LIN_NEG_BASE + 9'(i[3:0]);
      end else begin
         lin_addr = LIN_NEG_BASE;
      end
   endfunction

   wire [8:0] lin_sel = lin_addr(lin_index_in);

   ////////////////////////////////////////////////////////////////////////
   // Results, ready, clock pin
   logic [15:0] temp_q, p1z_q, p0z_q, p1x_q, p0x_q; // Raw results
   logic [15:0] mag_q, ang_q, pos_q, crc_q; // Computed results
   logic ready_q; // Results valid
   logic clk_mon_q; // Divided internal clock
   logic tick_q; // External clock edge
   logic [15:0] lin_q; // Selected table entry
   logic [15:0] cz_q, cx_q; // CORDIC inputs

   wire rdy_clr = rd_stb & ((rd_adr == ADR_RDY_CLR) | (rd_adr == ADR_POS));
   wire flip = coord_sel & magnet_orientation_in;
   wire [15:0] pos_d = flip ? 16'(-linearized_position_in) : linearized_position_in;
   wire [15:0] status_w = (16'(ready_q) << ST_RDY) | (16'(magnet_orientation_in) << ST_DIR)
      | (16'(done_q) << ST_DONE);

   // Result latch on measurement end
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         {temp_q, p1z_q, p0z_q, p1x_q, p0x_q} <= '0;
         {mag_q, ang_q, pos_q, crc_q} <= '0;
         ready_q <= 1'b0;
      end else if (ce_in) begin
         ready_q <= meas_done_in | (ready_q & ~rdy_clr); // see R21
         if (meas_done_in) begin
            temp_q <= temperature_in; // see R1
            p1z_q <= pixel1_z_field_in; // see R2
            p0z_q <= pixel0_z_field_in;
            p1x_q <= pixel1_x_field_in;
            p0x_q <= pixel0_x_field_in;
            mag_q <= magnitude_in; // see R3
            ang_q <= raw_angle_in; // see R5
            pos_q <= pos_d; // see R20
            crc_q <= checksum_in; // see R25
         end
      end
   end

   // CORDIC input mux, clock pin and table entry
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         cz_q <= 16'h0000;
         cx_q <= 16'h0000;
         clk_mon_q <= 1'b0;
         tick_q <= 1'b0;
         lin_q <= 16'h0000;
      end else if (ce_in) begin
         cz_q <= differential_select_out ? 16'(pixel0_z_field_in - pixel1_z_field_in)
            : pixel1_z_field_in; // see R4
         cx_q <= differential_select_out ? 16'(pixel0_x_field_in - pixel1_x_field_in)
            : pixel1_x_field_in; // see R3
         clk_mon_q <= ~clk_mon_q; // see R24
         tick_q <= extsel_q[1] & cpin_q[1] & ~cpin_q[2];
         lin_q <= nvm_q[lin_sel]; // see R9
      end
   end

   assign ready_out = ready_q;
   assign cordic_z_out = cz_q;
   assign cordic_x_out = cx_q;
   assign lin_entry_out = lin_q;
   assign clk_pin_out = clk_mon_q;
   assign clk_pin_oe_out = ~extsel_q[1]; // see R24
   assign ext_clk_tick_out = tick_q;

   // Register read decode
   always_comb begin
      unique case (rd_adr)
         ADR_SEQ: rd_data = seq_q;
         ADR_NVM_ADR: rd_data = nadr_q;
         ADR_NVM_DAT: rd_data = nvm_rd; // see R10
         ADR_PG_ADR: rd_data = padr_q;
         ADR_RDY_CLR, ADR_STATUS: rd_data = status_w;
         ADR_CRC: rd_data = crc_q;
         ADR_TEMP: rd_data = temp_q;
         ADR_P1Z: rd_data = p1z_q;
         ADR_P0Z: rd_data = p0z_q;
         ADR_P1X: rd_data = p1x_q;
         ADR_P0X: rd_data = p0x_q;
         ADR_MAG: rd_data = mag_q;
         ADR_ANG: rd_data = ang_q; // see R18
         ADR_POS: rd_data = pos_q; // see R6
         default: rd_data = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   property p_done_low;
      st_q == NVM_BUSY |-> !done_q;
   endproperty
   a_done_low: assert property (p_done_low) else $error("done high while busy"); // see R13

   property p_done_set;
      ce_in && commit |=> done_q && idle;
   endproperty
   a_done_set: assert property (p_done_set) else $error("done not set"); // see R11

   property p_ready_set;
      ce_in && meas_done_in |=> ready_out;
   endproperty
   a_ready_set: assert property (p_ready_set) else $error("ready not set"); // see R21

   property p_ready_clr;
      ce_in && rdy_clr && !meas_done_in |=> !ready_out;
   endproperty
   a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared"); // see R21

   property p_miso_sel;
      ce_in && !miso_oe_out |=> cnt_q == 5'h00 && !miso_out;
   endproperty
   a_miso_sel: assert property (p_miso_sel) else $error("frame left over when idle"); // see R22

   property p_sign;
      ce_in && meas_done_in && flip |=> pos_q == 16'(-$past(linearized_position_in));
   endproperty
   a_sign: assert property (p_sign) else $error("position not negated"); // see R20

   property p_diff;
      ce_in && differential_select_out |=>
         cordic_z_out == 16'($past(pixel0_z_field_in) - $past(pixel1_z_field_in));
   endproperty
   a_diff: assert property (p_diff) else $error("differential input wrong"); // see R4

   property p_page_hold;
      ce_in && pg_wr |=> idle && pval_q[$past(padr_q[2:0])];
   endproperty
   a_page_hold: assert property (p_page_hold) else $error("page word started write"); // see R16

   property p_range;
      ce_in && wr_stb && cmd_adr_q == ADR_SEQ && !reload_q |=>
         range_extension_enable_out == $past(sh_nx[BIT_RANGE_EXT]);
   endproperty
   a_range: assert property (p_range) else $error("range bit not applied"); // see R19

   property p_temp;
      ce_in && meas_done_in |=> temp_q == $past(temperature_in);
   endproperty
   a_temp: assert property (p_temp) else $error("temperature not latched"); // see R1

   c_page: cover property (commit && cm_page_q);
   c_single: cover property (commit && !cm_page_q);
   c_rdy_clr: cover property (ready_q ##1 rdy_clr);
   c_read: cover property (rd_stb ##[1:400] dat_end);
endmodule // position_result_and_nvm_access

`default_nettype wire

// File: logic/pos_pkg.sv
// Purpose: Shared constants for the position result bank and NVM access
// Assumes: 20 MHz core clock, 16-bit register words
// Notes: Register offsets are word addresses carried in the serial command
package pos_pkg;
   // Core clock period
   localparam int unsigned CLK_PERIOD_NS = 50;
   // Time to program one word or one page
   localparam int unsigned NVM_WRITE_US = 10000;
   // Longest write time rounded down to cycles
   localparam int unsigned NVM_WRITE_CYC = NVM_WRITE_US * 1000 / CLK_PERIOD_NS;
   // Register offsets
   localparam logic [9:0] ADR_SEQ = 10'h00b;
   localparam logic [9:0] ADR_NVM_ADR = 10'h030;
   localparam logic [9:0] ADR_NVM_DAT = 10'h031;
   localparam logic [9:0] ADR_PG_ADR = 10'h032;
   localparam logic [9:0] ADR_PG_DAT = 10'h033;
   localparam logic [9:0] ADR_RDY_CLR = 10'h100;
   localparam logic [9:0] ADR_STATUS = 10'h107;
   localparam logic [9:0] ADR_CRC = 10'h108;
   localparam logic [9:0] ADR_TEMP = 10'h110;
   localparam logic [9:0] ADR_P1Z = 10'h111;
   localparam logic [9:0] ADR_P0Z = 10'h112;
   localparam logic [9:0] ADR_P1X = 10'h113;
   localparam logic [9:0] ADR_P0X = 10'h114;
   localparam logic [9:0] ADR_MAG = 10'h120;
   localparam logic [9:0] ADR_ANG = 10'h121;
   localparam logic [9:0] ADR_POS = 10'h122;
   // Sequencer control fields
   localparam int unsigned BIT_RANGE_EXT = 11;
   localparam int unsigned BIT_COORD = 10;
   localparam int unsigned BIT_DIFF = 9;
   localparam logic [15:0] SEQ_RESET = 16'h0000;
   // Status fields
   localparam int unsigned ST_RDY = 15;
   localparam int unsigned ST_DIR = 1;
   localparam int unsigned ST_DONE = 0;
   // NVM word locations
   localparam logic [8:0] NVM_SEQ_WORD = 9'h00b;
   localparam logic [8:0] NVM_PWM_WORD = 9'h00d;
   localparam logic [8:0] NVM_LOST_WORD = 9'h00f;
   localparam logic [8:0] LIN_ENTRY16 = 9'h05f;
   localparam logic [8:0] LIN_POS_BASE = 9'h060;
   localparam logic [8:0] LIN_NEG_BASE = 9'h070;
   // Serial frame layout
   localparam int unsigned CMD_READ_BIT = 15;
   localparam logic [4:0] CMD_LAST = 5'h0f;
   localparam logic [4:0] DAT_LAST = 5'h1f;
   localparam logic [4:0] TX_SHIFT_FROM = 5'h11;
   // Programming engine states
   typedef enum logic {NVM_IDLE, NVM_BUSY} nvm_state_e;
endpackage

// File: testbench/spi_host_model.sv
// Purpose: Serial host that frames commands into the device
// Assumes: Mode 0, MSB first, 8 core cycles per serial bit (400 ns)
// Notes: Serial clock idles low outside frames
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
   input wire logic mclk_in,
   input wire logic miso_in,
   output logic sclk_out,
   output logic mosi_out,
   output logic cs_n_out
);
   // Idle levels at time zero
   initial begin
      sclk_out = 1'b0;
      mosi_out = 1'b0;
      cs_n_out = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // Step n core cycles, then move off the edge
   task automatic gap(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   // Frame of nb bits; keep leaves select low for the next one
   task automatic frame(input logic [31:0] w, input int nb, input bit keep,
      output logic [15:0] rd);
      int i;
      rd = 16'h0000;
      cs_n_out = 1'b0;
      gap(4);
      for (i = 31; i >= 32 - nb; i--) begin
         mosi_out = w[i]; // Data moves while clock is low
         gap(4);
         sclk_out = 1'b1;
         if (i < 16) rd[i] = miso_in; // Answer taken at rising edge
         gap(4);
         sclk_out = 1'b0;
      end
      mosi_out = ~mosi_out; // No stale level after the frame
      gap(4);
      if (!keep) cs_n_out = 1'b1;
      gap(4);
   endtask
endmodule // spi_host_model
`default_nettype wire

// File: testbench/tb_position_result_and_nvm_access.sv
// Purpose: Self-checking bench for the result bank and NVM access
// Assumes: Host model drives the serial port at 400 ns per bit
// Notes: Programming time shortened to 400 cycles
`timescale 1ns/100ps
`default_nettype none
module tb_position_result_and_nvm_access;
   import pos_pkg::*;
   localparam int unsigned WCYC = 400; // Short programming time
   localparam logic [9:0] RES_ADR [9] = '{ADR_CRC, ADR_TEMP, ADR_P1Z, ADR_P0Z, ADR_P1X,
      ADR_P0X, ADR_MAG, ADR_ANG, ADR_POS};
   logic mclk = 1'b0; // Core clock
   logic rst_n = 1'b0;
   logic ce = 1'b1; // Clock enable
   logic clk_pin = 1'b0;
   logic ext_sel = 1'b0;
   logic meas_done = 1'b0;
   logic orient = 1'b0;
   logic signed [5:0] lin_idx = 6'sh00;
   logic sclk, mosi, cs_n, miso, miso_oe, ready, clk_o, clk_oe, tick, rng, diff;
   logic [15:0] res [9]; // Result inputs in RES_ADR order
   logic [15:0] pg [8]; // Page data
   logic [15:0] lin_entry, cz, cx, rdv, r16, rneg;
   wire miso_line; // Data line as the host sees it
   integer seed = 32'hbde39b8c;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int ticks = 0;
   int k;
   // Undriven line floats when deselected
   assign miso_line = miso_oe ? miso : 1'bz;
   always #25 mclk = ~mclk;
   ////////////////////////////////////////////////////////////
   position_result_and_nvm_access #(.WRITE_CYCLES(WCYC)) u_position_result_and_nvm_access (
      .mclk_in(mclk), .rst_n_in(rst_n), .ce_in(ce), .sclk_in(sclk), .mosi_in(mosi),
      .cs_n_in(cs_n), .miso_out(miso), .miso_oe_out(miso_oe), .ready_out(ready),
      .clk_pin_in(clk_pin), .clk_pin_out(clk_o), .clk_pin_oe_out(clk_oe),
      .clk_ext_select_in(ext_sel), .ext_clk_tick_out(tick), .meas_done_in(meas_done),
      .temperature_in(res[1]), .pixel1_z_field_in(res[2]), .pixel0_z_field_in(res[3]),
      .pixel1_x_field_in(res[4]), .pixel0_x_field_in(res[5]), .magnitude_in(res[6]),
      .raw_angle_in(res[7]), .linearized_position_in(res[8]), .checksum_in(res[0]),
      .magnet_orientation_in(orient), .lin_index_in(lin_idx), .lin_entry_out(lin_entry),
      .cordic_z_out(cz), .cordic_x_out(cx), .range_extension_enable_out(rng),
      .differential_select_out(diff));
   spi_host_model u_spi_host_model (.mclk_in(mclk), .miso_in(miso_line), .sclk_out(sclk),
      .mosi_out(mosi), .cs_n_out(cs_n));
   ////////////////////////////////////////////////////////////
   // Cycle count, hang limit and external tick count
   always @(negedge mclk) begin
      cyc++;
      if (tick === 1'b1) ticks++;
      if (cyc == 60000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [9:0] a, input logic [15:0] v);
      u_spi_host_model.frame({6'h00, a, v}, 32, 1'b0, rdv);
   endtask
   task automatic rd(input logic [9:0] a, input bit keep);
      u_spi_host_model.frame({6'h20, a, 16'h0000}, 32, keep, rdv);
   endtask
   // Host polls write-done before any further programming
   task automatic wait_done();
      int n;
      n = 0;
      rd(ADR_STATUS, 1'b0);
      while (rdv[ST_DONE] !== 1'b1 && n < 10) begin
         rd(ADR_STATUS, 1'b0);
         n++;
      end
      check("write_done", {15'h0000, rdv[ST_DONE]}, 16'h0001);
   endtask
   // Address to areg, data to the commit register, then busy and done
   task automatic nvm_wr(input logic [9:0] areg, input logic [9:0] a, input logic [15:0] v);
      wr(areg, a);
      wr(ADR_NVM_DAT, v);
      rd(ADR_STATUS, 1'b0);
      check("busy", {15'h0000, rdv[ST_DONE]}, 16'h0000);
      wait_done();
   endtask
   task automatic nvm_rd(input logic [9:0] a, input logic [15:0] v);
      wr(ADR_NVM_ADR, a);
      rd(ADR_NVM_DAT, 1'b0);
      check("nvm_data", rdv, v);
   endtask
   task automatic lin_chk(input logic signed [5:0] i, input logic [15:0] v);
      lin_idx = i;
      settle(2);
      check("lin_entry", lin_entry, v);
   endtask
   // Fresh random results latched by one done pulse
   task automatic meas();
      foreach (res[i]) res[i] = 16'($random(seed));
      meas_done = 1'b1;
      settle(1);
      meas_done = 1'b0;
      settle(2);
   endtask
   function automatic logic [15:0] exp_pos(input logic [15:0] v, input logic s, input logic o);
      return (s && o) ? -v : v;
   endfunction
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      foreach (res[i]) res[i] = 16'h0000;
      settle(12);
      rst_n = 1'b1;
      settle(4);
      check("ready_rst", {15'h0000, ready}, 16'h0000);
      check("clk_oe", {15'h0000, clk_oe}, 16'h0001);
      rdv = {15'h0000, ~clk_o};
      settle(1);
      check("clk_mon", {15'h0000, clk_o}, rdv);
      rd(ADR_STATUS, 1'b0);
      check("done_rst", {15'h0000, rdv[ST_DONE]}, 16'h0001);
      // Result bank read back with select held low
      meas();
      check("ready_set", {15'h0000, ready}, 16'h0001);
      for (k = 0; k < 9; k++) begin
         rd(RES_ADR[k], k < 8);
         check("result", rdv, res[k]);
         check("ready_hold", {15'h0000, ready}, {15'h0000, k < 8});
      end
      // Read-only write ignored, unmapped reads zero
      wr(ADR_CRC, ~res[0]);
      rd(ADR_CRC, 1'b0);
      check("ro_write", rdv, res[0]);
      rd(10'h1ff, 1'b0);
      check("unmapped", rdv, 16'h0000);
      orient = 1'b1;
      meas();
      rd(ADR_RDY_CLR, 1'b0);
      check("status", rdv & 16'h8003, 16'h8003);
      check("ready_clr", {15'h0000, ready}, 16'h0000);
      // Clock enable low freezes the result bank
      ce = 1'b0;
      meas();
      check("ce_freeze", {15'h0000, ready}, 16'h0000);
      ce = 1'b1;
      // Sequencer options: range, sign, differential
      wr(ADR_SEQ, 16'h0e00);
      check("seq_out", {14'h0000, rng, diff}, 16'h0003);
      rd(ADR_SEQ, 1'b0);
      check("seq_rd", rdv, 16'h0e00);
      meas();
      check("cordic_z", cz, res[3] - res[2]);
      check("cordic_x", cx, res[5] - res[4]);
      rd(ADR_POS, 1'b0);
      check("pos_neg", rdv, exp_pos(res[8], 1'b1, orient));
      wr(ADR_SEQ, 16'h0000);
      check("cordic_z_abs", cz, res[2]);
      check("cordic_x_abs", cx, res[4]);
      // Frame cut short changes nothing
      u_spi_host_model.frame({6'h00, ADR_SEQ, 16'h0800}, 20, 1'b0, rdv);
      check("abort", {15'h0000, rng}, 16'h0000);
      check("miso_idle", {15'h0000, miso_oe}, 16'h0000);
      // Single word writes and table endpoints
      nvm_wr(ADR_NVM_ADR, {1'b0, NVM_SEQ_WORD}, 16'h0000);
      r16 = 16'($random(seed));
      rneg = 16'($random(seed));
      nvm_wr(ADR_NVM_ADR, {1'b0, LIN_ENTRY16}, r16);
      nvm_wr(ADR_NVM_ADR, {1'b0, LIN_NEG_BASE}, rneg);
      nvm_rd({1'b0, LIN_ENTRY16}, r16);
      // Page of entries 0..7, committed by the eighth word
      for (k = 0; k < 8; k++) pg[k] = 16'($random(seed));
      for (k = 0; k < 7; k++) begin
         wr(ADR_PG_ADR, {1'b0, LIN_POS_BASE} + 10'(k));
         wr(ADR_PG_DAT, pg[k]);
      end
      rd(ADR_STATUS, 1'b0);
      check("no_commit", {15'h0000, rdv[ST_DONE]}, 16'h0001);
      nvm_wr(ADR_PG_ADR, {1'b0, LIN_POS_BASE} + 10'h007, pg[7]);
      for (k = 0; k < 8; k++) nvm_rd({1'b0, LIN_POS_BASE} + 10'(k), pg[k]);
      for (k = 0; k < 8; k++) lin_chk(6'(k), pg[k]);
      lin_chk(6'sd16, r16);
      lin_chk(-6'sd16, rneg);
      // Stored sequencer word reloads the options
      nvm_wr(ADR_NVM_ADR, {1'b0, NVM_SEQ_WORD}, 16'h0800);
      check("seq_reload", {14'h0000, rng, diff}, 16'h0002);
      // Clock pin accepts an external clock
      ext_sel = 1'b1;
      settle(4);
      check("clk_oe_ext", {15'h0000, clk_oe}, 16'h0000);
      k = ticks;
      repeat (5) begin
         clk_pin = 1'b1;
         settle(4);
         clk_pin = 1'b0;
         settle(4);
      end
      settle(4);
      check("ext_ticks", 16'(ticks - k), 16'h0005);
      finish_test();
   end
endmodule // tb_position_result_and_nvm_access
`default_nettype wire
